// ==== bench/fieldbus_master_model.sv ====
// Fieldbus master model issuing polls over the register bus
`default_nettype none
module fieldbus_master_model
  import poll_map_pkg::*;
(
  // Clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output var  logic        hsel,
  output var  logic [7:0]  haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic        hung
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {hsel, haddr, hwrite, hwdata, hung} = '0;
    htrans = HTRANS_IDLE;
    hsize  = 3'h2;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    q = hrdata;
    // Released data lines must not keep the last value
    hwdata <= ~d;
    if (n >= 64) hung <= 1'b1;
  endtask
  task automatic poll(input logic [11:0] sp, input logic on);
    logic [31:0] q;
    xfer(ADDR_POLL_LO, 1'b1, {20'h0, sp}, q);
    xfer(ADDR_POLL_HI, 1'b1, {31'h0, on}, q);
  endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ==== bench/poll_map_props.sv ====
// Checker of bus answers and plant output relations
`default_nettype none
module poll_map_props
  import poll_map_pkg::*;
(
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire logic [7:0]    haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire plant_out_type plant_out,
  input wire logic          response_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic req;
  assign req = hsel && hready && htrans[1];
  AST_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  AST_POLL: assert property (req && hwrite && haddr == ADDR_POLL_HI |-> ##2 response_pulse)
    else $error("poll without response");
  AST_CAUSE: assert property (response_pulse |-> $past(req && hwrite && haddr == ADDR_POLL_HI, 2))
    else $error("response without poll");
  AST_MID: assert property (req && !hwrite && haddr == ADDR_RESP_MID |=> hrdata == 32'h0)
    else $error("unused response bytes not zero");
  AST_NIB: assert property (req && !hwrite && haddr == ADDR_RESP_LO |=>
    hrdata[15:12] == 4'h0 && hrdata[31:28] == 4'h0) else $error("readback high nibble set");
  AST_FWD: assert property (plant_out.host_mode == plant_out.regulate_forward)
    else $error("host mode not forward regulation");
  AST_STICKY: assert property (plant_out.host_mode |=> plant_out.host_mode)
    else $error("host mode dropped");
  AST_USER: assert property (!plant_out.host_mode |-> plant_out.setpoint_code == 12'h000)
    else $error("setpoint in user mode");
  AST_ALARM: assert property (plant_out.alarm_indicator |=> !plant_out.output_enable)
    else $error("output on during alarm");
  AST_ILK: assert property (plant_out.output_enable |-> plant_out.interlock_indicator ||
    $past(plant_out.interlock_indicator)) else $error("output on with open interlock");
endmodule // poll_map_props
bind fieldbus_poll_io_mapper poll_map_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .plant_out(plant_out),
  .response_pulse(response_pulse));
`default_nettype wire

// ==== bench/tb_fieldbus_poll_io_mapper.sv ====
// Self-checking bench of the fieldbus poll mapper
`default_nettype none
module tb_fieldbus_poll_io_mapper;
  timeunit 1ns;
  timeprecision 100ps;
  import poll_map_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, response_pulse, hung;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [1:0] flash;
  plant_in_type pin;
  plant_out_type pout;
  int n_mismatch, checks, n_poll, n_pulse;
  fieldbus_master_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(hung));
  // Short timeout keeps the run brief
  fieldbus_poll_io_mapper #(.TIMEOUT_CYCLES(200), .BLINK_CYCLES(8)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .plant_in(pin), .plant_out(pout),
    .response_pulse(response_pulse));
  initial begin hclk = 0; forever #5 hclk = ~hclk; end
  always @(posedge hclk) if (response_pulse === 1'b1) n_pulse++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle; repeat (6) @(posedge hclk); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    m.xfer(a, 1'b0, 32'h0, q);
    check(q, e);
  endtask
  task automatic p(input logic on); n_poll++; m.poll(12'habc, on); endtask
  task automatic stop_test;
    if (hung === 1'b1) n_mismatch++;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    hresetn = 0;
    pin = '0;
    {pin.mains_ok, pin.phases_ok, pin.interlock_closed, pin.user_output_enable} = 4'hf;
    pin.fwd_raw = 16'h1234;
    pin.refl_raw = 16'hfff0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    check(pout.host_mode, 0);
    check(pout.output_enable, 1);
    check(pout.mains_present_indicator, 1);
    m.xfer(ADDR_CTRL, 1'b1, 32'h1, q);
    settle;
    check({pout.host_mode, pout.regulate_forward}, 2'h3);
    p(1); p(1); settle;
    check(pout.setpoint_code, 12'habc);
    check({pout.output_enable, pout.output_enabled_indicator}, 2'h3);
    rd(ADDR_RESP_LO, 32'h0fff_0123);
    rd(ADDR_RESP_HI, 32'h15);
    rd(8'h40, 32'h0);
    pin.power_limited <= 1'b1; settle;
    check({pout.power_limit_indicator, pout.output_enable}, 2'h3);
    pin.power_limited <= 1'b0; pin.user_output_enable <= 1'b0; settle;
    check(pout.output_enable, 0);
    pin.user_output_enable <= 1'b1; pin.interlock_closed <= 1'b0; settle;
    check({pout.output_enable, pout.interlock_indicator}, 2'h0);
    pin.interlock_closed <= 1'b1; p(1); settle;
    check({pout.output_enable, pout.interlock_indicator}, 2'h3);
    pin.temp_over <= 1'b1; settle;
    check({pout.overheat_indicator, pout.alarm_indicator, pout.output_enable}, 3'h6);
    p(1); rd(ADDR_RESP_HI, 32'h10);
    pin.temp_over <= 1'b0; p(1); settle;
    check(pout.output_enable, 0);
    p(0); p(1); settle;
    check({pout.alarm_indicator, pout.output_enable}, 2'h1);
    pin.setpoint_reached <= 1'b1; settle;
    p(1); rd(ADDR_RESP_HI, 32'h17);
    pin.temp_warn <= 1'b1;
    settle;
    flash = 2'h0;
    repeat (16) begin
      @(posedge hclk);
      flash = flash | {pout.overheat_indicator, !pout.overheat_indicator};
    end
    check(flash, 2'h3);
    pin.temp_warn <= 1'b0;
    repeat (260) @(posedge hclk);
    check({pout.output_enable, pout.setpoint_code}, 13'h0);
    pin.phases_ok <= 1'b0; settle;
    check(pout.mains_present_indicator, 0);
    check(n_pulse, n_poll);
    stop_test;
  end
endmodule // tb_fieldbus_poll_io_mapper
`default_nettype wire

// ==== src/fieldbus_poll_io_mapper.sv ====
// Fieldbus poll command interpreter with generator control and indicators
// Contract
// - Power-up selects user control mode
// - Engaging fieldbus switches to host mode
// - Host mode regulates on forward power
// - User connector output enable still honoured
// - Command byte 4 bit 0 requests output
// - Setpoint is 16-bit shifted into 12 bits; the code takes command bits 11:0 unshifted
// - Setpoint above full scale is clamped
// - Setpoint scales linearly to full power
// - Nine-byte response, power readbacks low first
// - Byte 8 reports output and setpoint state
// - Byte 8 reports temperature and interlock
// - Readbacks shifted to 12 bits, clamped
// - Readbacks scale linearly to full scale
// - Output indicator steady on, flashes on error
// - Mains indicator needs power and three phases
// - Poll timeout forces zero setpoint, output off; the code times out only while the ADDR_CTRL engage bit is set
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`default_nettype none
module fieldbus_poll_io_mapper
  import poll_map_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = poll_map_pkg::POLL_TIMEOUT_CYC,
  parameter int unsigned BLINK_CYCLES   = poll_map_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [7:0]                haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Plant side, asynchronous inputs
  input  wire poll_map_pkg::plant_in_type plant_in,
  // Plant side outputs
  output poll_map_pkg::plant_out_type    plant_out,
  output logic                           response_pulse
);
  import poll_map_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    plant_in_type  sync1;
    plant_in_type  sync2;
    logic [1:0]    warm;
    logic          ph_valid;
    logic          ph_write;
    logic [7:0]    ph_addr;
    logic [31:0]   rdata;
    logic [31:0]   cmd_lo;
    logic [7:0]    cmd_hi;
    logic          engaged;
    logic          host_mode;
    logic          on_request;
    logic [11:0]   setpoint;
    logic          fault_latched;
    logic          over_latched;
    logic          timed_out;
    logic [31:0]   idle_cnt;
    logic [31:0]   blink_cnt;
    logic          blink;
    logic [31:0]   resp_lo;
    logic [31:0]   resp_mid;
    logic [7:0]    resp_hi;
    logic [15:0]   resp_count;
    logic          resp_pulse;
    plant_out_type outs;
  } state_type;

  state_type st;
  state_type next_st;

  // Shift a 16-bit code to 12 bits, clamp at full scale
  function automatic logic [11:0] to_code(input logic [15:0] raw);
    logic [15:0] shifted;
    shifted = raw >> 4;
    if (shifted > {4'h0, FULL_SCALE}) begin
      to_code = FULL_SCALE;
    end else begin
      to_code = shifted[11:0];
    end
  endfunction

  logic         bus_take;
  plant_in_type pin;
  logic         alarm_now;
  logic         out_allowed;
  logic         poll_now;
  logic [15:0]  cmd_sp_raw;

  always_comb begin
    next_st    = st;
    bus_take   = hsel && hready && htrans[1];
    pin        = st.sync2;
    poll_now   = 1'b0;
    cmd_sp_raw = 16'h0000;

    // ========================================================================
    // Input synchronisers
    next_st.sync1 = plant_in;
    next_st.sync2 = st.sync1;
    // Sync stages hold reset zeros at first; no alarm until filled
    next_st.warm  = {st.warm[0], 1'b1};

    // ========================================================================
    // Bus data phase
    next_st.ph_valid = bus_take;
    next_st.ph_write = hwrite;
    next_st.ph_addr  = haddr;
    if (st.ph_valid && st.ph_write) begin
      case (st.ph_addr)
        ADDR_POLL_LO: next_st.cmd_lo = hwdata;
        ADDR_POLL_HI: begin
          next_st.cmd_hi = hwdata[7:0];
          poll_now       = 1'b1;
        end
        ADDR_CTRL: next_st.engaged = hwdata[CTRL_ENGAGE_BIT];
        default: ;
      endcase
    end
    if (bus_take && !hwrite) begin
      case (haddr)
        ADDR_POLL_LO:  next_st.rdata = st.cmd_lo;
        ADDR_POLL_HI:  next_st.rdata = {24'h0, st.cmd_hi};
        ADDR_CTRL:     next_st.rdata = {31'h0, st.engaged};
        ADDR_RESP_LO:  next_st.rdata = st.resp_lo;
        ADDR_RESP_MID: next_st.rdata = st.resp_mid;
        ADDR_RESP_HI:  next_st.rdata = {24'h0, st.resp_hi};
        ADDR_STATUS:   next_st.rdata = {st.resp_count, 11'h0, st.timed_out,
                                        st.over_latched, st.fault_latched,
                                        st.host_mode, st.on_request};
        ADDR_SETPOINT: next_st.rdata = {20'h0, st.setpoint};
        default:       next_st.rdata = RESET_WORD;
      endcase
    end

    // ========================================================================
    // Mode selection
    if (st.engaged) begin
      next_st.host_mode = 1'b1;
    end

    // ========================================================================
    // Poll command decode; byte 0 and low nibble of byte 1 carry setpoint, byte 4 bit 0 the on request
    if (poll_now) begin
      cmd_sp_raw         = {st.cmd_lo[11:8], st.cmd_lo[7:0], 4'h0};
      next_st.setpoint   = to_code(cmd_sp_raw);
      next_st.on_request = hwdata[CMD_ON_BIT];
      next_st.idle_cnt   = 32'h0;
      next_st.timed_out  = 1'b0;
    end else if (st.idle_cnt >= TIMEOUT_CYCLES - 1) begin
      next_st.timed_out = st.engaged;
    end else begin
      next_st.idle_cnt = st.idle_cnt + 32'h1;
    end
    if (st.timed_out) begin
      next_st.setpoint   = 12'h000;
      next_st.on_request = 1'b0;
    end

    // ========================================================================
    // Protection latches, cleared by an output-off command once healthy
    alarm_now = st.warm[1] &&
                (pin.temp_over || pin.protect_trip || !(pin.mains_ok && pin.phases_ok));
    if (pin.temp_over) begin
      next_st.over_latched = 1'b1;
    end else if (poll_now && !hwdata[CMD_ON_BIT] && !pin.temp_warn) begin
      next_st.over_latched = 1'b0;
    end
    if (alarm_now) begin
      next_st.fault_latched = 1'b1;
    end else if (poll_now && !hwdata[CMD_ON_BIT]) begin
      next_st.fault_latched = 1'b0;
    end

    // ========================================================================
    // Output control; user enable is always required too
    out_allowed = pin.interlock_closed && pin.user_output_enable
                  && !st.fault_latched && !st.over_latched;
    next_st.outs.output_enable    = out_allowed &&
                                    (st.host_mode ? st.on_request : 1'b1);
    next_st.outs.setpoint_code    = st.host_mode ? st.setpoint : 12'h000;
    next_st.outs.host_mode        = st.host_mode;
    next_st.outs.regulate_forward = st.host_mode;

    // ========================================================================
    // Indicators
    if (st.blink_cnt >= BLINK_CYCLES - 1) begin
      next_st.blink_cnt = 32'h0;
      next_st.blink     = !st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 32'h1;
    end
    next_st.outs.mains_present_indicator = pin.mains_ok && pin.phases_ok;
    next_st.outs.output_enabled_indicator =
      st.fault_latched ? st.blink : st.outs.output_enable;
    next_st.outs.interlock_indicator   = pin.interlock_closed;
    next_st.outs.power_limit_indicator = pin.power_limited;
    next_st.outs.overheat_indicator    =
      st.over_latched ? 1'b1 : (pin.temp_warn && st.blink);
    next_st.outs.alarm_indicator       = st.fault_latched;

    // ========================================================================
    // Response built from current values, once per poll
    next_st.resp_pulse = 1'b0;
    if (poll_now) begin
      next_st.resp_lo = {4'h0, to_code(pin.refl_raw),
                         4'h0, to_code(pin.fwd_raw)};
      next_st.resp_mid = RESET_WORD;
      next_st.resp_hi  = 8'h00;
      next_st.resp_hi[RSP_ON_BIT]   = st.outs.output_enable;
      next_st.resp_hi[RSP_SP_BIT]   = pin.setpoint_reached;
      next_st.resp_hi[RSP_TEMP_BIT] = !pin.temp_over && !st.over_latched;
      next_st.resp_hi[RSP_ILK_BIT]  = pin.interlock_closed;
      next_st.resp_count = st.resp_count + 16'h1;
      next_st.resp_pulse = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata         = st.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign plant_out      = st.outs;
  assign response_pulse = st.resp_pulse;
endmodule // fieldbus_poll_io_mapper
`default_nettype wire

// ==== src/poll_map_pkg.sv ====
// Package: constants and carrier types for the fieldbus poll I/O mapper
`default_nettype none
package poll_map_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned POLL_TIMEOUT_MS  = 100;
  localparam int unsigned POLL_TIMEOUT_CYC = POLL_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_HALF_MS    = 250;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * 1000 * CLK_MHZ;
  // ==========================================================================
  // Register map (word offsets, byte addresses)
  localparam logic [7:0] ADDR_POLL_LO   = 8'h00;  // cmd bytes 0..3
  localparam logic [7:0] ADDR_POLL_HI   = 8'h04;  // cmd byte 4, write = post poll
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_RESP_LO   = 8'h0c;  // resp bytes 0..3
  localparam logic [7:0] ADDR_RESP_MID  = 8'h10;  // resp bytes 4..7
  localparam logic [7:0] ADDR_RESP_HI   = 8'h14;  // resp byte 8
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_SETPOINT  = 8'h1c;
  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_ENGAGE_BIT  = 0;
  localparam int unsigned CMD_ON_BIT       = 0;
  localparam int unsigned RSP_ON_BIT       = 0;
  localparam int unsigned RSP_SP_BIT       = 1;
  localparam int unsigned RSP_TEMP_BIT     = 2;
  localparam int unsigned RSP_ILK_BIT      = 4;
  localparam logic [11:0] FULL_SCALE       = 12'hfff;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] { HTRANS_IDLE = 2'h0, HTRANS_BUSY = 2'h1,
                             HTRANS_NONSEQ = 2'h2, HTRANS_SEQ = 2'h3 } htrans_type;
  typedef struct packed {
    logic        mains_ok;
    logic        phases_ok;
    logic        interlock_closed;
    logic        user_output_enable;
    logic        temp_warn;
    logic        temp_over;
    logic        protect_trip;
    logic        power_limited;
    logic        setpoint_reached;
    logic [15:0] fwd_raw;
    logic [15:0] refl_raw;
  } plant_in_type;
  typedef struct packed {
    logic        output_enable;
    logic [11:0] setpoint_code;
    logic        host_mode;
    logic        regulate_forward;
    logic        mains_present_indicator;
    logic        output_enabled_indicator;
    logic        interlock_indicator;
    logic        power_limit_indicator;
    logic        overheat_indicator;
    logic        alarm_indicator;
  } plant_out_type;
endpackage
`default_nettype wire
